// File: logic/dual_gated_encoder_counter.sv
// two gated 32-bit encoder counters with process image and parameters
// Function
// R1 - each channel shows its live 32-bit signed count in the input image
// R2 - status bit 2 shows the software gate
// R3 - status bit 5 shows the internal gate
// R4 - status bit 7 set while counting backward
// R5 - status bit 8 set while counting forward
// R6 - status bit 11 set on overflow past the upper limit
// R7 - status bit 12 set on underflow past the lower limit
// R8 - status bit 13 set when the count passes through zero
// R9 - those three flags hold until control bit 6 rises
// R10 - control bit 2 opens, bit 10 closes the software gate
// R11 - control bit 5 forces the count to zero
// R12 - filter byte codes 02h..04h and 06h..09h select max input frequency; others refused
// R13 - each of the four tracks has its own glitch filter
// R14 - filter settings reset to code 02h
// R15 - options bit 3 inverts track B direction; other bits fixed zero
// R16 - mode bytes are taken only while the system is stopped
// R17 - rising control edges move the gate; internal gate follows it
// R18 - counting wraps between upper and lower limit both ways
// R19 - evaluation bits select off, single, double, quadruple or pulse/direction
// R20 - opening the software gate clears the count
// R21 - reserved status bits read zero; reserved control bits are ignored
// R22 - gate closed: count holds, direction still follows the tracks
`timescale 1ns/100ps
`default_nettype none
module dual_gated_encoder_counter (
  input  wire logic        clock,            // system clock, 100 MHz
  input  wire logic        reset_n,          // async reset, active low
  input  wire logic [1:0]  track_a,          // track A per channel
  input  wire logic [1:0]  track_b,          // track B per channel
  input  wire logic [15:0] counter0_control, // channel 0 control word
  input  wire logic [15:0] counter1_control, // channel 1 control word
  input  wire logic        stopped,          // system in stop state
  input  wire logic        param_write,      // parameter byte write strobe
  input  wire logic [2:0]  param_index,      // parameter byte index
  input  wire logic [7:0]  param_wdata,      // parameter byte to write
  output logic      [31:0] counter0_value,   // channel 0 count
  output logic      [31:0] counter1_value,   // channel 1 count
  output logic      [15:0] counter0_status,  // channel 0 status word
  output logic      [15:0] counter1_status,  // channel 1 status word
  output logic      [7:0]  param_rdata       // parameter byte at param_index
);

  logic [enc_pkg::TICK_W-1:0] tick_cnt_q;
  logic                       tick;
  logic [7:0]                 filter_q [4];
  logic [7:0]                 options_q [2];
  logic [7:0]                 eval_q [2];
  logic [7:0]                 rdata_q;
  logic [3:0]                 raw_w;
  logic [3:0]                 clean_w;
  logic [15:0]                ctrl_w [2];
  logic [31:0]                value_w [2];
  logic [15:0]                status_w [2];

  assign ctrl_w[0]       = counter0_control;
  assign ctrl_w[1]       = counter1_control;
  assign counter0_value  = value_w[0];
  assign counter1_value  = value_w[1];
  assign counter0_status = status_w[0];
  assign counter1_status = status_w[1];
  assign param_rdata     = rdata_q;

  // filter time base
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign tick = (tick_cnt_q == enc_pkg::TICK_W'(enc_pkg::TICK_CYCLES - 1));

  // parameter record; bad filter codes and running mode writes are dropped
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        filter_q[i] <= enc_pkg::FILTER_RESET; // [R14]
      end
      for (int i = 0; i < 2; i++) begin
        options_q[i] <= enc_pkg::OPTIONS_RESET;
        eval_q[i]    <= enc_pkg::EVAL_RESET;
      end
    end else if (param_write) begin
      case (param_index)
        enc_pkg::PAR_C0_TRACK_A_FILTER, enc_pkg::PAR_C0_TRACK_B_FILTER,
        enc_pkg::PAR_C1_TRACK_A_FILTER, enc_pkg::PAR_C1_TRACK_B_FILTER: begin
          if (enc_pkg::filter_code_legal(param_wdata)) begin // [R12]
            filter_q[param_index[1:0]] <= param_wdata;
          end
        end
        enc_pkg::PAR_C0_MODE_OPTIONS, enc_pkg::PAR_C1_MODE_OPTIONS: begin
          if (stopped) begin // [R16]
            options_q[param_index[1]] <= param_wdata & enc_pkg::OPTIONS_MASK; // [R15]
          end
        end
        enc_pkg::PAR_C0_SIGNAL_EVALUATION, enc_pkg::PAR_C1_SIGNAL_EVALUATION: begin
          if (stopped) begin // [R16]
            eval_q[param_index[1]] <= param_wdata & enc_pkg::EVAL_MASK;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (param_index[2]) begin
      rdata_q <= param_index[0] ? eval_q[param_index[1]] : options_q[param_index[1]];
    end else begin
      rdata_q <= filter_q[param_index[1:0]];
    end
  end

  // one filter per track: even index track A, odd index track B
  for (genvar t = 0; t < 4; t++) begin : g_track
    assign raw_w[t] = (t % 2 == 1) ? track_b[t / 2] : track_a[t / 2];
    track_filter u_filter ( // [R13]
      .clock   (clock),
      .reset_n (reset_n),
      .tick    (tick),
      .raw     (raw_w[t]),
      .code    (filter_q[t]),
      .clean   (clean_w[t])
    );
  end

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [15:0] ctrl_prev_q;
    logic        open_rise;
    logic        close_rise;
    logic        ack_rise;
    logic        gate_start;
    logic        soft_gate_q;
    logic        a_q;
    logic        b_q;
    logic        inv_b;
    logic        a_now;
    logic        b_now;
    logic        b_old;
    logic        pulse;
    logic        up;
    logic        step;
    logic        clearing;
    logic [31:0] count_q;
    logic        dir_up_q;
    logic        dir_dn_q;
    logic        overflow_q;
    logic        underflow_q;
    logic        zero_pass_q;
    logic        ovf_ev;
    logic        unf_ev;
    logic        zero_ev;

    // only the named control bits are looked at
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        ctrl_prev_q <= 16'h0000;
      end else begin
        ctrl_prev_q <= ctrl_w[c];
      end
    end
    assign open_rise  = ctrl_w[c][enc_pkg::CT_GATE_OPEN] &
                        ~ctrl_prev_q[enc_pkg::CT_GATE_OPEN]; // [R17] [R21]
    assign close_rise = ctrl_w[c][enc_pkg::CT_GATE_CLOSE] &
                        ~ctrl_prev_q[enc_pkg::CT_GATE_CLOSE]; // [R17]
    assign ack_rise   = ctrl_w[c][enc_pkg::CT_FLAG_ACK] &
                        ~ctrl_prev_q[enc_pkg::CT_FLAG_ACK];
    assign gate_start = open_rise & ~close_rise & ~soft_gate_q;

    // close wins when both edges come together
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        soft_gate_q <= 1'b0;
      end else if (close_rise) begin
        soft_gate_q <= 1'b0; // [R10]
      end else if (open_rise) begin
        soft_gate_q <= 1'b1; // [R10]
      end
    end

    // track decoding
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        a_q <= 1'b0;
        b_q <= 1'b0;
      end else begin
        a_q <= clean_w[2 * c];
        b_q <= clean_w[2 * c + 1];
      end
    end
    assign inv_b = options_q[c][enc_pkg::OPT_INVERT_B];
    assign a_now = clean_w[2 * c];
    assign b_now = clean_w[2 * c + 1] ^ inv_b; // [R15]
    assign b_old = b_q ^ inv_b;

    always_comb begin
      pulse = 1'b0;
      up    = 1'b0;
      case (eval_q[c][2:0]) // [R19]
        enc_pkg::EV_SINGLE, enc_pkg::EV_PULSE_DIR: begin
          pulse = a_now & ~a_q;
          up    = ~b_now;
        end
        enc_pkg::EV_DOUBLE: begin
          pulse = a_now ^ a_q;
          up    = a_now ^ b_now;
        end
        enc_pkg::EV_QUAD: begin
          pulse = (a_now ^ a_q) ^ (b_now ^ b_old);
          up    = (a_now ^ a_q) ? (a_now ^ b_now) : ~(a_now ^ b_now);
        end
        default: begin
        end
      endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        dir_up_q <= 1'b0;
        dir_dn_q <= 1'b0;
      end else if (pulse) begin
        dir_up_q <= up; // [R5] [R22]
        dir_dn_q <= ~up; // [R4]
      end
    end

    // counting
    assign clearing = ctrl_w[c][enc_pkg::CT_CLEAR] | gate_start;
    assign step     = soft_gate_q & pulse & ~clearing; // [R22]
    assign ovf_ev   = step & up & (count_q == enc_pkg::COUNT_MAX);
    assign unf_ev   = step & ~up & (count_q == enc_pkg::COUNT_MIN);
    assign zero_ev  = step & (up ? (count_q == enc_pkg::COUNT_M1) :
                                   (count_q == enc_pkg::COUNT_ONE));

    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        count_q <= enc_pkg::COUNT_RESET;
      end else if (clearing) begin
        count_q <= enc_pkg::COUNT_RESET; // [R11] [R20]
      end else if (step) begin
        count_q <= up ? count_q + enc_pkg::COUNT_ONE :
                        count_q - enc_pkg::COUNT_ONE; // [R18]
      end
    end

    // sticky flags; a new event beats the acknowledge edge
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        overflow_q  <= 1'b0;
        underflow_q <= 1'b0;
        zero_pass_q <= 1'b0;
      end else begin
        overflow_q  <= ovf_ev | (overflow_q & ~ack_rise); // [R6] [R9]
        underflow_q <= unf_ev | (underflow_q & ~ack_rise); // [R7] [R9]
        zero_pass_q <= zero_ev | (zero_pass_q & ~ack_rise); // [R8] [R9]
      end
    end

    assign value_w[c] = count_q; // [R1]

    always_comb begin
      status_w[c]                         = 16'h0000; // [R21]
      status_w[c][enc_pkg::ST_SOFT_GATE]  = soft_gate_q; // [R2]
      status_w[c][enc_pkg::ST_INT_GATE]   = soft_gate_q; // [R3]
      status_w[c][enc_pkg::ST_COUNT_DOWN] = dir_dn_q;
      status_w[c][enc_pkg::ST_COUNT_UP]   = dir_up_q;
      status_w[c][enc_pkg::ST_OVERFLOW]   = overflow_q;
      status_w[c][enc_pkg::ST_UNDERFLOW]  = underflow_q;
      status_w[c][enc_pkg::ST_ZERO_PASS]  = zero_pass_q;
    end
  end

endmodule
`default_nettype wire

// File: logic/enc_pkg.sv
// shared constants for the dual encoder counter
package enc_pkg;

  // clock and filter time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 7;
  localparam int unsigned HOLD_W        = 10;

  // least stable time of a track level: half the period of the max frequency
  localparam int unsigned HOLD_100K_NS = 5000;
  localparam int unsigned HOLD_60K_NS  = 8333;
  localparam int unsigned HOLD_30K_NS  = 16666;
  localparam int unsigned HOLD_10K_NS  = 50000;
  localparam int unsigned HOLD_5K_NS   = 100000;
  localparam int unsigned HOLD_2K_NS   = 250000;
  localparam int unsigned HOLD_1K_NS   = 500000;

  localparam logic [HOLD_W-1:0] HOLD_100K = HOLD_W'(HOLD_100K_NS / TICK_NS);
  localparam logic [HOLD_W-1:0] HOLD_60K  = HOLD_W'(HOLD_60K_NS / TICK_NS);
  localparam logic [HOLD_W-1:0] HOLD_30K  = HOLD_W'(HOLD_30K_NS / TICK_NS);
  localparam logic [HOLD_W-1:0] HOLD_10K  = HOLD_W'(HOLD_10K_NS / TICK_NS);
  localparam logic [HOLD_W-1:0] HOLD_5K   = HOLD_W'(HOLD_5K_NS / TICK_NS);
  localparam logic [HOLD_W-1:0] HOLD_2K   = HOLD_W'(HOLD_2K_NS / TICK_NS);
  localparam logic [HOLD_W-1:0] HOLD_1K   = HOLD_W'(HOLD_1K_NS / TICK_NS);

  // input filter codes
  localparam logic [7:0] FILT_100K    = 8'h02;
  localparam logic [7:0] FILT_60K     = 8'h03;
  localparam logic [7:0] FILT_30K     = 8'h04;
  localparam logic [7:0] FILT_10K     = 8'h06;
  localparam logic [7:0] FILT_5K      = 8'h07;
  localparam logic [7:0] FILT_2K      = 8'h08;
  localparam logic [7:0] FILT_1K      = 8'h09;
  localparam logic [7:0] FILTER_RESET = FILT_100K;

  // mode bytes
  localparam logic [7:0] OPTIONS_RESET = 8'h00;
  localparam logic [7:0] EVAL_RESET    = 8'h00;
  localparam logic [7:0] OPTIONS_MASK  = 8'h08;
  localparam logic [7:0] EVAL_MASK     = 8'h07;
  localparam int unsigned OPT_INVERT_B = 3;
  localparam logic [2:0] EV_OFF        = 3'h0;
  localparam logic [2:0] EV_SINGLE     = 3'h1;
  localparam logic [2:0] EV_DOUBLE     = 3'h2;
  localparam logic [2:0] EV_QUAD       = 3'h3;
  localparam logic [2:0] EV_PULSE_DIR  = 3'h4;

  // parameter record indices
  localparam logic [2:0] PAR_C0_TRACK_A_FILTER    = 3'h0;
  localparam logic [2:0] PAR_C0_TRACK_B_FILTER    = 3'h1;
  localparam logic [2:0] PAR_C1_TRACK_A_FILTER    = 3'h2;
  localparam logic [2:0] PAR_C1_TRACK_B_FILTER    = 3'h3;
  localparam logic [2:0] PAR_C0_MODE_OPTIONS      = 3'h4;
  localparam logic [2:0] PAR_C0_SIGNAL_EVALUATION = 3'h5;
  localparam logic [2:0] PAR_C1_MODE_OPTIONS      = 3'h6;
  localparam logic [2:0] PAR_C1_SIGNAL_EVALUATION = 3'h7;

  // process image byte offsets
  localparam logic [3:0] IN_COUNTER0_VALUE    = 4'h0;
  localparam logic [3:0] IN_COUNTER1_VALUE    = 4'h4;
  localparam logic [3:0] IN_COUNTER0_STATUS   = 4'h8;
  localparam logic [3:0] IN_COUNTER1_STATUS   = 4'ha;
  localparam logic [3:0] OUT_COUNTER0_CONTROL = 4'h0;
  localparam logic [3:0] OUT_COUNTER1_CONTROL = 4'h2;

  // status and control bit positions
  localparam int unsigned ST_SOFT_GATE  = 2;
  localparam int unsigned ST_INT_GATE   = 5;
  localparam int unsigned ST_COUNT_DOWN = 7;
  localparam int unsigned ST_COUNT_UP   = 8;
  localparam int unsigned ST_OVERFLOW   = 11;
  localparam int unsigned ST_UNDERFLOW  = 12;
  localparam int unsigned ST_ZERO_PASS  = 13;
  localparam int unsigned CT_GATE_OPEN  = 2;
  localparam int unsigned CT_CLEAR      = 5;
  localparam int unsigned CT_FLAG_ACK   = 6;
  localparam int unsigned CT_GATE_CLOSE = 10;

  // count range
  localparam logic [31:0] COUNT_MAX   = 32'h7fffffff;
  localparam logic [31:0] COUNT_MIN   = 32'h80000000;
  localparam logic [31:0] COUNT_ONE   = 32'h00000001;
  localparam logic [31:0] COUNT_M1    = 32'hffffffff;
  localparam logic [31:0] COUNT_RESET = 32'h00000000;

  function automatic logic filter_code_legal(input logic [7:0] code);
    case (code)
      FILT_100K, FILT_60K, FILT_30K, FILT_10K,
      FILT_5K, FILT_2K, FILT_1K: filter_code_legal = 1'b1;
      default: filter_code_legal = 1'b0;
    endcase
  endfunction

  function automatic logic [HOLD_W-1:0] filter_hold(input logic [7:0] code);
    case (code)
      FILT_60K: filter_hold = HOLD_60K;
      FILT_30K: filter_hold = HOLD_30K;
      FILT_10K: filter_hold = HOLD_10K;
      FILT_5K:  filter_hold = HOLD_5K;
      FILT_2K:  filter_hold = HOLD_2K;
      FILT_1K:  filter_hold = HOLD_1K;
      default:  filter_hold = HOLD_100K;
    endcase
  endfunction

endpackage

// File: logic/track_filter.sv
// glitch filter for one encoder track
`timescale 1ns/100ps
`default_nettype none
module track_filter (
  input  wire logic       clock,   // system clock
  input  wire logic       reset_n, // async reset, active low
  input  wire logic       tick,    // one pulse per filter time unit
  input  wire logic       raw,     // unfiltered track level
  input  wire logic [7:0] code,    // input filter code
  output logic            clean    // filtered track level
);

  logic [enc_pkg::HOLD_W-1:0] run_q;
  logic [enc_pkg::HOLD_W-1:0] hold;
  logic                       clean_q;

  assign hold  = enc_pkg::filter_hold(code);
  assign clean = clean_q;

  // a new level must stand until the hold-th filter tick after it changed before it is passed on
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_q   <= '0;
      clean_q <= 1'b0;
    end else if (raw == clean_q) begin
      run_q <= '0;
    end else if (tick) begin
      if (run_q + 1'b1 >= hold) begin
        clean_q <= raw;
        run_q   <= '0;
      end else begin
        run_q <= run_q + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/dual_gated_encoder_counter_sva.sv
// port assertions for the dual encoder counter
`timescale 1ns/100ps
`default_nettype none
module dual_gated_encoder_counter_sva (
  input  wire logic        clock,            // clock
  input  wire logic        reset_n,          // reset
  input  wire logic [1:0]  track_a,          // track A
  input  wire logic [1:0]  track_b,          // track B
  input  wire logic [15:0] counter0_control, // control 0
  input  wire logic [15:0] counter1_control, // control 1
  input  wire logic        stopped,          // stop state
  input  wire logic        param_write,      // param strobe
  input  wire logic [2:0]  param_index,      // param index
  input  wire logic [7:0]  param_wdata,      // param data
  input  wire logic [31:0] counter0_value,   // count 0
  input  wire logic [31:0] counter1_value,   // count 1
  input  wire logic [15:0] counter0_status,  // status 0
  input  wire logic [15:0] counter1_status,  // status 1
  input  wire logic [7:0]  param_rdata       // param readback
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_open;
    $rose(counter0_control[2]) && !$rose(counter0_control[10]) && !counter0_status[2];
  endsequence
  sequence s_mode_wr;
    param_write && stopped && param_index[2] ##1 (!param_write && $stable(param_index))[*2];
  endsequence
  sequence s_mode_drop;
    param_write && !stopped && param_index[2] ##1 (!param_write && $stable(param_index))[*2];
  endsequence
  sequence s_onto_zero;
    $past(counter0_status[5]) && !$past(counter0_control[5]) && counter0_value == 32'h0
      && ($past(counter0_value) == 32'h1 || $past(counter0_value) == 32'hffffffff);
  endsequence

  AST_GATE_OPEN: assert property (s_open |=> counter0_status[2] && counter0_value == 32'h0)
    else $error("gate open did not clear and open");
  AST_GATE_CLOSE: assert property ($rose(counter0_control[10]) |=> !counter0_status[2])
    else $error("gate close not seen");
  AST_GATE_HOLD: assert property (counter0_status[2] && !$rose(counter0_control[10])
    |=> counter0_status[2]) else $error("gate dropped by itself");
  AST_INT_GATE: assert property (counter0_status[5] == counter0_status[2]
    && counter1_status[5] == counter1_status[2]) else $error("internal gate mismatch");
  AST_DIR: assert property (!(counter0_status[7] && counter0_status[8]))
    else $error("both direction bits set");
  AST_CLEAR: assert property (counter0_control[5] |=> counter0_value == 32'h0)
    else $error("count not cleared");
  AST_ACK: assert property ($rose(counter0_control[6]) ##1 $stable(counter0_value)
    |-> counter0_status[13:11] == 3'h0) else $error("flags not acknowledged");
  AST_STICKY: assert property ($fell(counter0_status[13])
    |-> $past(counter0_control[6]) && !$past(counter0_control[6], 2))
    else $error("zero pass flag fell without ack");
  AST_ZERO_PASS: assert property (s_onto_zero |-> counter0_status[13])
    else $error("zero pass not flagged");
  AST_OVERFLOW: assert property ($past(counter0_value) == enc_pkg::COUNT_MAX
    && counter0_value == enc_pkg::COUNT_MIN |-> counter0_status[11])
    else $error("overflow not flagged");
  AST_UNDERFLOW: assert property ($past(counter0_value) == enc_pkg::COUNT_MIN
    && counter0_value == enc_pkg::COUNT_MAX |-> counter0_status[12])
    else $error("underflow not flagged");
  AST_RESERVED: assert property ((counter0_status & 16'hc65b) == 16'h0
    && (counter1_status & 16'hc65b) == 16'h0) else $error("reserved status bit set");
  AST_MODE_MASK: assert property (s_mode_wr |=> param_rdata == ($past(param_wdata, 3)
    & (param_index[0] ? enc_pkg::EVAL_MASK : enc_pkg::OPTIONS_MASK)))
    else $error("mode byte not masked");
  AST_MODE_LOCK: assert property (s_mode_drop |=> param_rdata == $past(param_rdata, 2))
    else $error("mode byte taken while running");
endmodule
bind dual_gated_encoder_counter dual_gated_encoder_counter_sva sva (
  .clock(clock), .reset_n(reset_n), .track_a(track_a), .track_b(track_b),
  .counter0_control(counter0_control), .counter1_control(counter1_control),
  .stopped(stopped), .param_write(param_write), .param_index(param_index),
  .param_wdata(param_wdata), .counter0_value(counter0_value),
  .counter1_value(counter1_value), .counter0_status(counter0_status),
  .counter1_status(counter1_status), .param_rdata(param_rdata)
);
`default_nettype wire

// File: tb/dual_gated_encoder_counter_tb_top.sv
// testbench for the dual encoder counter
`timescale 1ns/100ps
`default_nettype none
module dual_gated_encoder_counter_tb_top;
  logic             clock = 1'b0;
  logic             reset_n = 1'b0;
  logic [1:0][15:0] ctrl;
  logic [1:0][31:0] value;
  logic [1:0][15:0] status;
  logic [1:0]       track_a;
  logic [1:0]       track_b;
  logic             stopped;
  logic             param_write;
  logic [2:0]       param_index;
  logic [7:0]       param_wdata;
  logic [7:0]       param_rdata;
  logic             go;
  logic             go_ch;
  logic             go_dir;
  logic             busy;
  int               error_cnt = 0;
  int               n_compared = 0;
  logic [31:0]      exp_cnt [5] = '{32'h0, 32'h1, 32'h2, 32'h4, 32'h1};
  logic [7:0]       codes [7] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h02};

  always #5 clock = ~clock;

  dual_gated_encoder_counter dut (
    .clock(clock), .reset_n(reset_n), .track_a(track_a), .track_b(track_b),
    .counter0_control(ctrl[0]), .counter1_control(ctrl[1]), .stopped(stopped),
    .param_write(param_write), .param_index(param_index), .param_wdata(param_wdata),
    .counter0_value(value[0]), .counter1_value(value[1]), .counter0_status(status[0]),
    .counter1_status(status[1]), .param_rdata(param_rdata)
  );
  enc_track_model encoder (
    .clock(clock), .go(go), .ch(go_ch), .dir(go_dir),
    .track_a(track_a), .track_b(track_b), .busy(busy)
  );

  task automatic chk_val(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_bit(input string w, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", w, e, g);
    end
  endtask
  task automatic chk_byte(input logic [2:0] i, input logic [7:0] e);
    param_index = i;
    repeat (3) @(negedge clock);
    n_compared++;
    if (param_rdata !== e) begin
      error_cnt++;
      $display("[FAIL] param %0d expected %h seen %h", i, e, param_rdata);
    end
  endtask
  task automatic ctrl_edge(input int ch, input int b);
    ctrl[ch][b] = 1'b1;
    repeat (2) @(negedge clock);
    ctrl[ch][b] = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    param_index = i;
    param_wdata = d;
    param_write = 1'b1;
    @(negedge clock);
    param_write = 1'b0;
    @(negedge clock);
  endtask
  task automatic spin(input logic ch, input logic dn);
    go_ch = ch;
    go_dir = dn;
    go = 1'b1;
    @(negedge clock);
    go = 1'b0;
    for (int k = 0; k < 8000 && busy; k++) @(negedge clock);
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #900_000;
    error_cnt++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    ctrl = '0;
    stopped = 1'b1;
    param_write = 1'b0;
    param_index = 3'h0;
    param_wdata = 8'h00;
    go = 1'b0;
    go_ch = 1'b0;
    go_dir = 1'b0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    for (int i = 0; i < 8; i++) chk_byte(i, (i < 4) ? 8'h02 : 8'h00);
    for (int c = 0; c < 2; c++) chk_val("count", 32'h0, value[c]);
    for (int c = 0; c < 2; c++) chk_val("status", 32'h0, {16'h0, status[c]});
    $display("test reset done");
    foreach (codes[i]) begin
      wr(3'h3, codes[i]);
      chk_byte(3'h3, codes[i]);
    end
    wr(3'h3, 8'h05);
    chk_byte(3'h3, 8'h02);
    stopped = 1'b0;
    wr(3'h5, 8'h03);
    chk_byte(3'h5, 8'h00);
    stopped = 1'b1;
    wr(3'h4, 8'hff);
    chk_byte(3'h4, 8'h08);
    wr(3'h4, 8'h00);
    $display("test parameters done");
    for (int m = 0; m < 5; m++) begin
      for (int c = 0; c < 2; c++) begin
        wr(3'(5 + 2 * c), 8'(m));
        ctrl_edge(c, 10);
        ctrl_edge(c, 2);
        chk_bit("soft gate", 1'b1, status[c][2]);
        spin(c[0], 1'b0);
        chk_val("count", exp_cnt[m], value[c]);
        if (m != 0) chk_bit("count up", 1'b1, status[c][8]);
      end
    end
    $display("test evaluation modes done");
    wr(3'h5, 8'h03);
    spin(1'b0, 1'b1);
    chk_val("count", 32'hfffffffd, value[0]);
    chk_bit("count down", 1'b1, status[0][7]);
    chk_bit("zero pass", 1'b1, status[0][13]);
    wr(3'h4, 8'h08);
    spin(1'b0, 1'b0);
    chk_val("count", 32'hfffffff9, value[0]);
    wr(3'h4, 8'h00);
    ctrl_edge(0, 10);
    chk_bit("soft gate", 1'b0, status[0][2]);
    spin(1'b0, 1'b0);
    chk_val("count", 32'hfffffff9, value[0]);
    chk_bit("count up", 1'b1, status[0][8]);
    $display("test direction and gate done");
    ctrl[0] = 16'hfb9b;
    repeat (3) @(negedge clock);
    ctrl[0] = 16'h0;
    chk_val("count", 32'hfffffff9, value[0]);
    chk_bit("zero pass", 1'b1, status[0][13]);
    ctrl_edge(0, 6);
    chk_bit("zero pass", 1'b0, status[0][13]);
    ctrl_edge(0, 2);
    chk_val("count", 32'h0, value[0]);
    spin(1'b0, 1'b0);
    ctrl[0][5] = 1'b1;
    repeat (2) @(negedge clock);
    chk_val("count", 32'h0, value[0]);
    ctrl[0][5] = 1'b0;
    $display("test flags and clear done");
    stop_test();
  end
endmodule
`default_nettype wire

// File: tb/enc_track_model.sv
// encoder partner model driving both channels' track lines
`timescale 1ns/100ps
`default_nettype none
module enc_track_model #(
  parameter int SPACE  = 800,
  parameter int GLITCH = 150
) (
  input  wire logic       clock,   // system clock
  input  wire logic       go,      // start one full quadrature cycle
  input  wire logic       ch,      // channel to move
  input  wire logic       dir,     // 1 = track B leads
  output logic      [1:0] track_a, // track A per channel
  output logic      [1:0] track_b, // track B per channel
  output logic            busy     // cycle in progress
);
  logic c;
  logic on_a;

  initial begin
    track_a = 2'h0;
    track_b = 2'h0;
    busy    = 1'b0;
    forever begin
      @(posedge clock iff go);
      busy = 1'b1;
      c    = ch;
      for (int i = 0; i < 4; i++) begin
        on_a = ((i % 2) == 0) ^ dir;
        // spike, restore, then the real step
        for (int k = 0; k < 3; k++) begin
          @(negedge clock);
          if (on_a) track_a[c] = ~track_a[c];
          else track_b[c] = ~track_b[c];
          repeat (GLITCH) @(negedge clock);
        end
        repeat (SPACE) @(negedge clock);
      end
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire
